// ### hdl/aswp_packer.sv
// aswp_packer.sv: packs 14-bit converter results into 16-bit sample words, wishbone registers
// assumes: one converter result per clock when sample_valid_in; classic wishbone master
//
// Summary of operation
// - result in bits 13..0, bit 13 msb
// - result spans full 14-bit signed range
// - standard mode: upper bits copy bit 13
// - digital only: dig1 to bit15, dig0 bit14
// - overrange only: ovr bit15, sign bit14
// - both: ovr bit15, dig0 bit14
// - read-only full-scale code register
// - digital enable works only with option present
// - fixed lag between analog and digital bits
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aswp_defs.svh"
module aswp_packer (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // converter and digital lines
  input wire logic sample_valid_in,
  input wire logic [13:0] adc_data_in,
  input wire logic adc_overrange_in,
  input wire logic [1:0] dig_in,
  // board strap: digital input option fitted
  input wire logic dig_option_in,
  // packed word stream out
  output logic word_valid_out,
  input wire logic word_ready_in,
  output logic [15:0] word_data_out,
  // sticky: the fifo could not take a sample
  output logic overflow_out,
  // wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [31:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // registers
  logic dig_en_q; // software digital record enable
  logic ovr_en_q; // software overrange detect enable
  logic opt_q; // option strap caught after reset
  logic opt_seen_q; // strap already caught
  logic overflow_q; // sticky lost-sample flag
  logic [31:0] rdata_q; // read data
  aswp_pkg::aswp_bus_t bus_q; // bus slave state
  logic [15:0] word_q; // packed word register
  logic word_vld_q; // packed word valid
  logic [1:0] dig_lag; // digital bits after board lag
  logic fifo_full;
  logic fifo_empty;
  logic wr_ack; // write taken this edge
  aswp_pkg::aswp_mode_t mode;
  logic [15:0] word_d;

  aswp_stream_if #(.WIDTH(`ASWP_WORD_W)) fill_if ();

  ////////////////////////////////////////////////////////////////////////////////
  // option strap caught by a clocked process after reset release
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      opt_q <= 1'b0;
      opt_seen_q <= 1'b0;
    end else if (!opt_seen_q) begin
      opt_q <= dig_option_in;
      opt_seen_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after strobe, dropped the next cycle
  // writes commit on the edge that carries ack, while the master still holds the request
  assign wr_ack = (bus_q == aswp_pkg::ASWP_BUS_ACK) && wb_cyc_in && wb_stb_in && wb_we_in;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_q <= aswp_pkg::ASWP_BUS_IDLE;
    end else begin
      case (bus_q)
        aswp_pkg::ASWP_BUS_IDLE: begin
          if (wb_cyc_in && wb_stb_in) begin
            bus_q <= aswp_pkg::ASWP_BUS_ACK;
          end
        end
        aswp_pkg::ASWP_BUS_ACK: begin
          bus_q <= aswp_pkg::ASWP_BUS_IDLE;
        end
        default: begin
          bus_q <= aswp_pkg::ASWP_BUS_IDLE;
        end
      endcase
    end
  end
  assign wb_ack_out = (bus_q == aswp_pkg::ASWP_BUS_ACK);
  assign wb_dat_out = rdata_q;

  // read mux, captured with the request; unmapped reads return zero
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= `ASWP_UNMAPPED_VAL;
    end else if (bus_q == aswp_pkg::ASWP_BUS_IDLE && wb_cyc_in && wb_stb_in && !wb_we_in) begin
      case (wb_adr_in)
        `ASWP_ADDR_FULL_SCALE: rdata_q <= `ASWP_FULL_SCALE_VAL;
        `ASWP_ADDR_DIG_EN: rdata_q <= {31'h0, dig_en_q};
        `ASWP_ADDR_CTRL: rdata_q <= {31'h0, ovr_en_q};
        `ASWP_ADDR_STATUS: rdata_q <= {29'h0, opt_q, fifo_empty, overflow_q};
        default: rdata_q <= `ASWP_UNMAPPED_VAL;
      endcase
    end
  end

  // digital enable, held low when option absent
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dig_en_q <= 1'b0;
    end else if (wr_ack && wb_adr_in == `ASWP_ADDR_DIG_EN && wb_sel_in[0]) begin
      dig_en_q <= wb_dat_in[`ASWP_DIG_EN_BIT] && opt_q;
    end
  end

  // overrange detection enable
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ovr_en_q <= 1'b0;
    end else if (wr_ack && wb_adr_in == `ASWP_ADDR_CTRL && wb_sel_in[0]) begin
      ovr_en_q <= wb_dat_in[`ASWP_CTRL_OVR_BIT];
    end
  end

  // sticky overflow: a new loss wins over a clear (write 1 to status bit 0)
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      overflow_q <= 1'b0;
    end else if (word_vld_q && fifo_full) begin
      overflow_q <= 1'b1;
    end else if (wr_ack && wb_adr_in == `ASWP_ADDR_STATUS && wb_sel_in[0]
                 && wb_dat_in[`ASWP_STAT_FULL_BIT]) begin
      overflow_q <= 1'b0;
    end
  end
  assign overflow_out = overflow_q;

  ////////////////////////////////////////////////////////////////////////////////
  // digital bits delayed by the board lag
  aswp_digital_lag u_lag (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .dig_in(dig_in),
    .dig_out(dig_lag)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // packing mode from the two enables
  always_comb begin
    case ({ovr_en_q, dig_en_q})
      2'h1: mode = aswp_pkg::ASWP_MODE_DIG;
      2'h2: mode = aswp_pkg::ASWP_MODE_OVR;
      2'h3: mode = aswp_pkg::ASWP_MODE_OVR_DIG;
      default: mode = aswp_pkg::ASWP_MODE_STD;
    endcase
  end

  // upper bits by mode; low 14 bits untouched in every mode
  always_comb begin
    word_d[`ASWP_ADC_MSB:0] = adc_data_in;
    case (mode)
      aswp_pkg::ASWP_MODE_DIG: word_d[`ASWP_HI_BIT:`ASWP_LO_BIT] = dig_lag;
      aswp_pkg::ASWP_MODE_OVR:
        word_d[`ASWP_HI_BIT:`ASWP_LO_BIT] = {adc_overrange_in, adc_data_in[`ASWP_ADC_MSB]};
      aswp_pkg::ASWP_MODE_OVR_DIG:
        word_d[`ASWP_HI_BIT:`ASWP_LO_BIT] = {adc_overrange_in, dig_lag[0]};
      default:
        word_d[`ASWP_HI_BIT:`ASWP_LO_BIT] = {2{adc_data_in[`ASWP_ADC_MSB]}};
    endcase
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_q <= 16'h0000;
      word_vld_q <= 1'b0;
    end else begin
      word_vld_q <= sample_valid_in;
      if (sample_valid_in) begin
        word_q <= word_d;
      end
    end
  end

  // the stream cannot pause the converter; a full fifo drops the word and flags it
  assign fill_if.valid = word_vld_q;
  assign fill_if.data = word_q;

  aswp_fifo #(.WIDTH(`ASWP_WORD_W), .DEPTH(`ASWP_FIFO_DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .wr(fill_if),
    .rd_valid_out(word_valid_out),
    .rd_ready_in(word_ready_in),
    .rd_data_out(word_data_out),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  // low field follows converter
  property p_low_field;
    @(posedge core_clk_in) disable iff (!resetn_in)
      sample_valid_in |=> word_q[`ASWP_ADC_MSB:0] == $past(adc_data_in);
  endproperty
  a_low_field: assert property (p_low_field) else $error("low field mismatch");
  property p_range;
    @(posedge core_clk_in) disable iff (!resetn_in)
      sample_valid_in |=> $signed(word_q[`ASWP_ADC_MSB:0]) == $signed($past(adc_data_in));
  endproperty
  a_range: assert property (p_range) else $error("signed value changed");
  property p_std;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (sample_valid_in && !ovr_en_q && !dig_en_q)
        |=> word_q[15:14] == {2{$past(adc_data_in[13])}};
  endproperty
  a_std: assert property (p_std) else $error("sign extension wrong");
  property p_dig;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (sample_valid_in && !ovr_en_q && dig_en_q) |=> word_q[15:14] == $past(dig_lag);
  endproperty
  a_dig: assert property (p_dig) else $error("digital bits wrong");
  property p_ovr;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (sample_valid_in && ovr_en_q && !dig_en_q)
        |=> word_q[15:14] == {$past(adc_overrange_in), $past(adc_data_in[13])};
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrange word wrong");
  property p_ovr_dig;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (sample_valid_in && ovr_en_q && dig_en_q)
        |=> word_q[15:14] == {$past(adc_overrange_in), $past(dig_lag[0])};
  endproperty
  a_ovr_dig: assert property (p_ovr_dig) else $error("overrange digital word wrong");
  property p_full_scale;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (bus_q == aswp_pkg::ASWP_BUS_IDLE && wb_cyc_in && wb_stb_in && !wb_we_in
       && wb_adr_in == `ASWP_ADDR_FULL_SCALE) |=> wb_ack_out && wb_dat_out == `ASWP_FULL_SCALE_VAL;
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("full scale read wrong");
  property p_dig_gate;
    @(posedge core_clk_in) disable iff (!resetn_in)
      !opt_q |-> !dig_en_q;
  endproperty
  a_dig_gate: assert property (p_dig_gate) else $error("digital enabled without option");
  property p_lag;
    @(posedge core_clk_in) disable iff (!resetn_in)
      ##2 dig_lag == $past(dig_in, 2);
  endproperty
  a_lag: assert property (p_lag) else $error("digital lag wrong");
  property p_rate;
    @(posedge core_clk_in) disable iff (!resetn_in)
      sample_valid_in |=> word_vld_q;
  endproperty
  a_rate: assert property (p_rate) else $error("sample word missing");
  // bus handshake, register writes and loss flag
  property p_ack_pulse;
    @(posedge core_clk_in) disable iff (!resetn_in)
      wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_dig_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (wr_ack && wb_adr_in == `ASWP_ADDR_DIG_EN && wb_sel_in[0])
        |=> dig_en_q == ($past(wb_dat_in[`ASWP_DIG_EN_BIT]) && opt_q);
  endproperty
  a_dig_write: assert property (p_dig_write) else $error("digital enable write wrong");
  property p_sel_gate;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (wr_ack && !wb_sel_in[0]) |=> $stable(dig_en_q) && $stable(ovr_en_q);
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("masked write took effect");
  property p_status_opt;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (bus_q == aswp_pkg::ASWP_BUS_IDLE && wb_cyc_in && wb_stb_in && !wb_we_in
       && wb_adr_in == `ASWP_ADDR_STATUS) |=> wb_dat_out[`ASWP_STAT_OPT_BIT] == opt_q;
  endproperty
  a_status_opt: assert property (p_status_opt) else $error("option bit read wrong");
  property p_loss_flag;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (word_vld_q && fifo_full) |=> overflow_q;
  endproperty
  a_loss_flag: assert property (p_loss_flag) else $error("dropped word not flagged");
  property p_word_hold;
    @(posedge core_clk_in) disable iff (!resetn_in)
      !sample_valid_in |=> $stable(word_q);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed without sample");
endmodule
`default_nettype wire

// ### hdl/aswp_defs.svh
// aswp_defs.svh: offsets, field positions, reset values and counts of the sample word packer
// assumes: included by bare name from the design files; definitions only
`ifndef ASWP_DEFS_SVH
`define ASWP_DEFS_SVH

// register map, byte addresses on the wishbone bus
`define ASWP_FULL_SCALE_IDX 32'h0000_0466
`define ASWP_DIG_EN_IDX 32'h0001_ae14
`define ASWP_ADDR_FULL_SCALE 32'h0000_1198
`define ASWP_ADDR_DIG_EN 32'h0006_b850
`define ASWP_ADDR_CTRL 32'h0000_0000
`define ASWP_ADDR_STATUS 32'h0000_0004
`define ASWP_ADDR_ANALOG_TO_DIGITAL_LAG 32'h0000_0008

// values read back
`define ASWP_FULL_SCALE_VAL 32'h0000_2000
`define ASWP_UNMAPPED_VAL 32'h0000_0000

// field positions
`define ASWP_CTRL_OVR_BIT 0
`define ASWP_DIG_EN_BIT 0
`define ASWP_STAT_FULL_BIT 0
`define ASWP_STAT_EMPTY_BIT 1
`define ASWP_STAT_OPT_BIT 2

// word layout
`define ASWP_ADC_MSB 13
`define ASWP_HI_BIT 15
`define ASWP_LO_BIT 14

// board lag in samples between analog and digital data
`define ASWP_DIG_LAG 2
`define ASWP_LAG_W 2

// fifo shape
`define ASWP_FIFO_DEPTH 16
`define ASWP_WORD_W 16

`endif

// ### hdl/aswp_pkg.sv
// aswp_pkg.sv: types of the sample word packer
// assumes: nothing; referenced as aswp_pkg::name
package aswp_pkg;
  // upper-bit packing mode, from overrange and digital enables
  typedef enum logic [1:0] {
    ASWP_MODE_STD,
    ASWP_MODE_DIG,
    ASWP_MODE_OVR,
    ASWP_MODE_OVR_DIG
  } aswp_mode_t;
  // bus slave state
  typedef enum logic [0:0] {
    ASWP_BUS_IDLE,
    ASWP_BUS_ACK
  } aswp_bus_t;
endpackage

// ### hdl/aswp_stream_if.sv
// aswp_stream_if.sv: valid/ready word stream between packer and fifo
// assumes: one clock domain shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface aswp_stream_if #(parameter int WIDTH = 16) ();
  logic valid; // word offered
  logic ready; // word accepted when both high
  logic [WIDTH-1:0] data; // packed word
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hdl/aswp_fifo.sv
// aswp_fifo.sv: synchronous fifo with valid/ready on both sides
// assumes: single clock, async active-low reset, depth a power of two
`timescale 1ns/1ps
`default_nettype none
module aswp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // fill side
  aswp_stream_if.dst wr,
  // drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out,
  // levels
  output logic full_out,
  output logic empty_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage
  logic [AW:0] wr_ptr_q; // extra bit tells full from empty
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  assign full_out = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign empty_out = (wr_ptr_q == rd_ptr_q);
  assign wr.ready = !full_out;
  assign rd_valid_out = !empty_out;
  assign rd_data_out = mem_q[rd_ptr_q[AW-1:0]];
  assign push = wr.valid && !full_out;
  assign pop = rd_ready_in && !empty_out;

  // storage write, no reset needed on data
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= wr.data;
    end
  end

  // pointers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/aswp_digital_lag.sv
// aswp_digital_lag.sv: fixed delay line bringing digital bits level with converter data
// assumes: one sample per clock; depth set by the board lag constant
`timescale 1ns/1ps
`default_nettype none
`include "aswp_defs.svh"
module aswp_digital_lag (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // digital bits in and delayed out
  input wire logic [1:0] dig_in,
  output logic [1:0] dig_out
);
  logic [1:0] stage_q [`ASWP_DIG_LAG]; // one stage per sample of lag

  // shift chain, one generate entry per stage
  for (genvar i = 0; i < `ASWP_DIG_LAG; i++) begin : g_stage
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        stage_q[i] <= 2'h0;
      end else if (i == 0) begin
        stage_q[i] <= dig_in;
      end else begin
        stage_q[i] <= stage_q[(i == 0) ? 0 : i-1];
      end
    end
  end
  assign dig_out = stage_q[`ASWP_DIG_LAG-1];
endmodule
`default_nettype wire

// ### verif/aswp_adc_model.sv
// aswp_adc_model.sv: behavioural converter and digital input lines in front of the packer
// assumes: bench clock and reset; run and slow come from the bench
`timescale 1ns/1ps
`default_nettype none
module aswp_adc_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // control from the bench
  input wire logic run_in,
  input wire logic slow_in,
  // converter result and digital lines
  output logic sample_valid_out,
  output logic [13:0] adc_data_out,
  output logic adc_overrange_out,
  output logic [1:0] dig_out
);
  int unsigned count_q; // results sent so far, picks the boundary codes
  ////////////////////////////////////////////////////////////////////////
  // one result per clock when fast, random gaps when slow
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sample_valid_out <= 1'b0;
      adc_data_out <= 14'h0000;
      adc_overrange_out <= 1'b0;
      count_q <= 0;
    end else if (run_in && (!slow_in || $urandom_range(1, 0) == 1)) begin
      sample_valid_out <= 1'b1;
      count_q <= count_q + 1;
      if (count_q % 8 == 0) begin
        adc_data_out <= count_q[3] ? 14'h1fff : 14'h2000;
      end else begin
        adc_data_out <= 14'($urandom);
      end
      adc_overrange_out <= 1'($urandom);
    end else begin
      // no result: lines toggle so stale data never looks valid
      sample_valid_out <= 1'b0;
      adc_data_out <= ~adc_data_out;
      adc_overrange_out <= ~adc_overrange_out;
    end
  end
  // digital lines change freely every clock, so the lag shows up
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dig_out <= 2'h0;
    end else begin
      dig_out <= 2'($urandom);
    end
  end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// tb_top.sv: self-checking bench of the sample word packer against a queue model
// assumes: design files under hdl; the partner model drives the converter side
`timescale 1ns/1ps
`default_nettype none
`include "aswp_defs.svh"
`define ASWP_TB_CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic clk = 0, resetn = 0, opt = 0, run = 0, slow = 0, word_ready = 1;
  logic wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, word_valid, ovf, sv, ovr;
  logic [31:0] wb_adr = 0, wb_wd = 0, wb_rd, rd;
  logic [3:0] wb_sel = 0;
  logic [15:0] word_data, exp_w;
  logic [13:0] adc;
  logic [1:0] dig, dh1, dh2;
  logic [15:0] exp_q[$]; // words expected out of the fifo, oldest first
  logic ovr_m = 0, den_m = 0; // modes as the model believes them
  int miscompares = 0, checks_done = 0, cycles = 0, vmin = 0, vmax = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  aswp_adc_model u_adc (.core_clk_in(clk), .resetn_in(resetn), .run_in(run), .slow_in(slow),
    .sample_valid_out(sv), .adc_data_out(adc), .adc_overrange_out(ovr), .dig_out(dig));
  aswp_packer DUT (.core_clk_in(clk), .resetn_in(resetn), .sample_valid_in(sv),
    .adc_data_in(adc), .adc_overrange_in(ovr), .dig_in(dig), .dig_option_in(opt),
    .word_valid_out(word_valid), .word_ready_in(word_ready), .word_data_out(word_data),
    .overflow_out(ovf), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wd), .wb_dat_out(wb_rd),
    .wb_ack_out(wb_ack));
  ////////////////////////////////////////////////////////////////////////
  // reference model: push a word per result, compare at each pop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      test_done();
    end
    if (!resetn) begin
      exp_q.delete();
      dh1 = 2'h0;
      dh2 = 2'h0;
    end else begin
      if (word_valid === 1'b1 && word_ready) begin
        vmin = ($signed(word_data[13:0]) < vmin) ? $signed(word_data[13:0]) : vmin;
        vmax = ($signed(word_data[13:0]) > vmax) ? $signed(word_data[13:0]) : vmax;
        exp_w = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
        `ASWP_TB_CHK("word", exp_w, word_data)
      end
      if (sv && exp_q.size() < `ASWP_FIFO_DEPTH) begin
        // upper bits by mode, digital bits two clocks late
        case ({ovr_m, den_m & opt})
          2'b00: exp_q.push_back({adc[13], adc[13], adc});
          2'b01: exp_q.push_back({dh2, adc});
          2'b10: exp_q.push_back({ovr, adc[13], adc});
          default: exp_q.push_back({ovr, dh2[0], adc});
        endcase
      end
      dh2 = dh1;
      dh1 = dig;
    end
  end
  // one classic wishbone cycle, held until ack is seen
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] wd,
                    input logic [3:0] sel, output logic [31:0] rdat);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wd <= wd;
    wb_sel <= sel;
    @(posedge clk);
    while (wb_ack !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 100) begin
        miscompares++;
        test_done();
      end
    end
    rdat = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
  endtask
  // reset with the option strap set as asked
  task automatic do_reset(input logic o);
    resetn <= 1'b0;
    opt <= o;
    ovr_m = 0;
    den_m = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // stream results, then drain with a stalling reader
  task automatic stream(input int n, input logic s, input logic stall);
    int k;
    word_ready <= !stall;
    slow <= s;
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    k = 0;
    while (exp_q.size() != 0 && k < 400) begin
      word_ready <= 1'($urandom);
      @(posedge clk);
      k++;
    end
    word_ready <= 1'b1;
    `ASWP_TB_CHK("words left", 0, exp_q.size())
  endtask
  // verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(69661));
    do_reset(1'b0);
    // option absent: constant, reserved place, ignored enable
    wb(1, `ASWP_ADDR_FULL_SCALE, 32'h0000_0001, 4'hf, rd);
    wb(0, `ASWP_ADDR_FULL_SCALE, 32'h0, 4'hf, rd);
    `ASWP_TB_CHK("full scale", `ASWP_FULL_SCALE_VAL, rd)
    wb(0, 32'h0000_0100, 32'h0, 4'hf, rd);
    `ASWP_TB_CHK("unmapped", `ASWP_UNMAPPED_VAL, rd)
    wb(1, `ASWP_ADDR_DIG_EN, 32'h0000_0001, 4'hf, rd);
    den_m = 1;
    wb(0, `ASWP_ADDR_DIG_EN, 32'h0, 4'hf, rd);
    `ASWP_TB_CHK("digital enable", 32'h0, rd)
    stream(40, 0, 0);
    do_reset(1'b1);
    wb(0, `ASWP_ADDR_STATUS, 32'h0, 4'hf, rd);
    `ASWP_TB_CHK("status", 32'h6, rd & 32'h7)
    wb(1, `ASWP_ADDR_DIG_EN, 32'h1, 4'he, rd);
    wb(0, `ASWP_ADDR_DIG_EN, 32'h0, 4'hf, rd);
    `ASWP_TB_CHK("masked write", 32'h0, rd)
    // every packing mode, fast and with gaps
    for (int m = 0; m < 8; m++) begin
      wb(1, `ASWP_ADDR_CTRL, 32'(m[1]), 4'hf, rd);
      wb(1, `ASWP_ADDR_DIG_EN, 32'(m[0]), 4'hf, rd);
      ovr_m = m[1];
      den_m = m[0];
      wb(0, `ASWP_ADDR_DIG_EN, 32'h0, 4'hf, rd);
      `ASWP_TB_CHK("digital enable", 32'(m[0]), rd)
      stream(60, m[2], 0);
    end
    // overfill the fifo while the reader stalls
    stream(24, 0, 1);
    `ASWP_TB_CHK("overflow", 1'b1, ovf)
    wb(1, `ASWP_ADDR_STATUS, 32'h1, 4'hf, rd);
    wb(0, `ASWP_ADDR_STATUS, 32'h0, 4'hf, rd);
    `ASWP_TB_CHK("overflow cleared", 32'h0, rd & 32'h1)
    `ASWP_TB_CHK("lowest code", -8192, vmin)
    `ASWP_TB_CHK("highest code", 8191, vmax)
    test_done();
  end
endmodule
`default_nettype wire
